// *** rtl/tvu_pkg.sv ***
package tvu_pkg;
  localparam int VEC_W = 24;
  localparam int SEG_W = 8;
  localparam int TRAPNO_W = 7;
  // Spacing code 0 places vectors four bytes apart
  localparam int VEC_BASE_SHIFT = 2;
  localparam logic [TRAPNO_W-1:0] TRAP_RESET = 7'h00;
  localparam logic [TRAPNO_W-1:0] TRAP_NMI = 7'h02;
  localparam logic [TRAPNO_W-1:0] TRAP_STACK_OVERFLOW_FLAG = 7'h04;
  localparam logic [TRAPNO_W-1:0] TRAP_STACK_UNDERFLOW_FLAG = 7'h06;
  localparam logic [TRAPNO_W-1:0] TRAP_SBRK = 7'h08;
  localparam logic [TRAPNO_W-1:0] TRAP_CLASS_B = 7'h0A;
  localparam logic [TRAPNO_W-1:0] TRAP_MOTOR_TIMER_A = 7'h4D;
  localparam logic [TRAPNO_W-1:0] TRAP_CLOCK_CALENDAR = 7'h5D;
  localparam logic [1:0] SPACING_RESET = 2'h0;
  localparam int FLAG_NMI = 0;
  localparam int FLAG_STACK_OVERFLOW_FLAG = 1;
  localparam int FLAG_STACK_UNDERFLOW_FLAG = 2;
  localparam int FLAG_SBRK = 3;
  localparam int FLAG_UNDEFINED_OPCODE_FLAG = 4;
  localparam int FLAG_PROGRAM_MEMORY_ACCESS_ERROR_FLAG = 5;
  localparam int FLAG_PROTECTED_INSTRUCTION_FAULT_FLAG = 6;
  localparam int FLAG_ILLEGAL_WORD_OPERAND_FLAG = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  typedef struct packed {
    logic [SEG_W-1:0] vector_segment;
    logic [1:0] vector_spacing;
  } tvu_cfg_t;

  typedef struct packed {
    logic valid;
    logic is_hw_trap;
    logic [TRAPNO_W-1:0] trap_number;
    logic [VEC_W-1:0] vector_address;
  } tvu_entry_t;
endpackage

// *** rtl/tvu_trap_unit.sv ***
`timescale 1ns/1ps
// What this block does
// - Vector table lies in programmable segment
// - Spacing field sets vector distance, default four
// - Hardware traps unmaskable, branch to vector immediately
// - Each hardware trap sets its flag bit
// - Traps wait only behind equal or higher trap service
// - Interrupts and transfers blocked during trap service
// - Resets vector to zero, set no flag
// - Class A traps own flag and vector
// - Class B traps share vector, separate flags
// - Software trap accepts numbers 00 to 7F
// - Each interrupt node has fixed trap number
module tvu_trap_unit
  import tvu_pkg::*;
#(
  parameter int NODES = 2
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Configuration from cpu_control_one and vector_segment_register
  input wire tvu_cfg_t CFG,
  // Reset causes (pulses): hardware, software, watchdog
  input wire logic [2:0] RESET_EVENT,
  // Hardware trap causes, one pulse per flag bit position
  input wire logic [7:0] HW_TRAP_EVENT,
  // Software trap instruction
  input wire logic SW_TRAP_REQ,
  input wire logic [TRAPNO_W-1:0] SW_TRAP_NUMBER,
  // Peripheral interrupt nodes, arbitrated here by lowest index
  input wire logic [NODES-1:0] IRQ_REQ,
  input wire logic PEC_REQ,
  // Core handshake
  input wire logic TRAP_SERVICE_DONE,
  input wire logic [7:0] FLAG_CLEAR,
  // Outputs
  output tvu_entry_t ENTRY,
  output logic [7:0] TRAP_FLAGS,
  output logic IN_TRAP_SERVICE,
  output logic PEC_GRANT
);

  // Fixed node numbers; index 0 motor timer, index 1 clock calendar
  function automatic logic [TRAPNO_W-1:0] node_number(input int idx);
    case (idx)
      0: node_number = TRAP_MOTOR_TIMER_A;
      1: node_number = TRAP_CLOCK_CALENDAR;
      default: node_number = TRAP_MOTOR_TIMER_A + TRAPNO_W'(idx);
    endcase
  endfunction

  // Spacing code 0 gives 4 bytes; each step doubles it
  function automatic logic [VEC_W-1:0] vec_addr(input tvu_cfg_t c,
                                                input logic [TRAPNO_W-1:0] n);
    logic [15:0] off;
    off = 16'(n) << (VEC_BASE_SHIFT + c.vector_spacing);
    vec_addr = {c.vector_segment, off};
  endfunction

  // One place builds every kind of entry
  function automatic tvu_entry_t make_entry(input tvu_cfg_t c,
                                            input logic hw,
                                            input logic [TRAPNO_W-1:0] n);
    tvu_entry_t e;
    e.valid = 1'h1;
    e.is_hw_trap = hw;
    e.trap_number = n;
    e.vector_address = vec_addr(c, n);
    make_entry = e;
  endfunction

  typedef enum logic [1:0] {ST_RUN, ST_TRAP_A, ST_TRAP_B} tvu_state_t;

  // Nothing is announced when no request wins this cycle
  localparam tvu_entry_t ENTRY_IDLE = '0;

  tvu_state_t state_r;
  tvu_state_t state_nxt;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  tvu_entry_t entry_r;
  tvu_entry_t entry_nxt;
  logic in_service_r;
  logic in_service_nxt;
  logic pec_grant_r;
  logic pec_grant_nxt;

  wire any_reset = |RESET_EVENT;
  wire [3:0] class_a = HW_TRAP_EVENT[FLAG_SBRK:FLAG_NMI];
  wire [3:0] class_b = HW_TRAP_EVENT[FLAG_ILLEGAL_WORD_OPERAND_FLAG:FLAG_UNDEFINED_OPCODE_FLAG];
  wire any_class_a = |class_a;
  wire any_class_b = |class_b;
  wire in_trap = (state_r != ST_RUN);
  wire in_trap_a = (state_r == ST_TRAP_A);
  wire irq_any = |IRQ_REQ;

  // Class A outranks class B; a trap waits only behind an equal or higher class
  wire take_a = any_class_a && !in_trap_a;
  wire take_b = any_class_b && !in_trap && !take_a;
  wire take_hw = take_a || take_b;
  // A trap service is never broken into by software traps, nodes or transfers
  wire take_sw = SW_TRAP_REQ && !in_trap && !take_hw;
  wire take_irq = irq_any && !in_trap && !take_hw && !take_sw;
  wire take_pec = PEC_REQ && !in_trap && !take_hw;

  // Lowest class A flag position wins when several arrive together
  wire [TRAPNO_W-1:0] a_num = class_a[FLAG_NMI] ? TRAP_NMI :
    class_a[FLAG_STACK_OVERFLOW_FLAG] ? TRAP_STACK_OVERFLOW_FLAG :
    class_a[FLAG_STACK_UNDERFLOW_FLAG] ? TRAP_STACK_UNDERFLOW_FLAG :
    TRAP_SBRK;

  // Lowest node index wins; nodes are levels, so a loser is retried later
  logic [TRAPNO_W-1:0] irq_num;
  always_comb begin
    irq_num = '0;
    for (int i = NODES - 1; i >= 0; i--) begin
      if (IRQ_REQ[i]) begin
        irq_num = node_number(i);
      end
    end
  end

  tvu_entry_t entry_reset;
  tvu_entry_t entry_a;
  tvu_entry_t entry_b;
  tvu_entry_t entry_sw;
  tvu_entry_t entry_irq;

  assign entry_reset = make_entry(CFG, 1'h0, TRAP_RESET);
  assign entry_a = make_entry(CFG, 1'h1, a_num);
  assign entry_b = make_entry(CFG, 1'h1, TRAP_CLASS_B);
  assign entry_sw = make_entry(CFG, 1'h0, SW_TRAP_NUMBER);
  assign entry_irq = make_entry(CFG, 1'h0, irq_num);

  // Reset, class A, class B, software trap, node
  assign entry_nxt = any_reset ? entry_reset :
                     take_a ? entry_a :
                     take_b ? entry_b :
                     take_sw ? entry_sw :
                     take_irq ? entry_irq :
                     ENTRY_IDLE;

  // Set wins over a same-cycle clear so no trap cause is lost
  assign flags_nxt = (flags_r & ~FLAG_CLEAR) | HW_TRAP_EVENT;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      ST_TRAP_A, ST_TRAP_B: begin
        if (TRAP_SERVICE_DONE) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    // Reset causes abort a service; a taken hardware trap opens one
    if (any_reset) begin
      state_nxt = ST_RUN;
    end else if (take_a) begin
      state_nxt = ST_TRAP_A;
    end else if (take_b) begin
      state_nxt = ST_TRAP_B;
    end
  end

  // A registered copy of the service state keeps the output glitch free
  assign in_service_nxt = (state_nxt != ST_RUN);
  assign pec_grant_nxt = take_pec;

  // Service state
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Trap flags
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      flags_r <= FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Entry announcement, valid for one cycle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      entry_r <= ENTRY_IDLE;
    end else begin
      entry_r <= entry_nxt;
    end
  end

  // Service flag output
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      in_service_r <= 1'h0;
    end else begin
      in_service_r <= in_service_nxt;
    end
  end

  // Transfer grant output
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pec_grant_r <= 1'h0;
    end else begin
      pec_grant_r <= pec_grant_nxt;
    end
  end

  assign ENTRY = entry_r;
  assign TRAP_FLAGS = flags_r;
  assign IN_TRAP_SERVICE = in_service_r;
  assign PEC_GRANT = pec_grant_r;

endmodule

// *** verif/tvu_chk.sv ***
`timescale 1ns/1ps
module tvu_chk import tvu_pkg::*; #(parameter int NODES = 2) (
  input wire logic CLOCK, RST_N, SW_TRAP_REQ, IN_TRAP_SERVICE, PEC_GRANT,
  input wire tvu_cfg_t CFG,
  input wire logic [2:0] RESET_EVENT,
  input wire logic [7:0] HW_TRAP_EVENT, TRAP_FLAGS,
  input wire logic [6:0] SW_TRAP_NUMBER,
  input wire logic [NODES-1:0] IRQ_REQ,
  input wire tvu_entry_t ENTRY);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire [3:0] ha = HW_TRAP_EVENT[3:0];
  wire go = RESET_EVENT == 3'h0 && !IN_TRAP_SERVICE;
  wire calm = go && HW_TRAP_EVENT == 8'h00;
  // Class A numbers run 2, 4, 6, 8 by bit position
  wire [6:0] na = {3'h0, ha[3], ha[1] | ha[2], ha[0] | ha[2], 1'h0};
  // The entry was formed from the configuration seen one edge earlier
  a_vector_addr: assert property (ENTRY.valid |->
    ENTRY.vector_address == {$past(CFG.vector_segment),
    16'(ENTRY.trap_number * (16'h0004 << $past(CFG.vector_spacing)))}) else $error("bad vector");
  a_reset_entry: assert property (RESET_EVENT != 3'h0 |=> ENTRY.valid &&
    ENTRY.trap_number == TRAP_RESET) else $error("bad reset entry");
  a_flag_set: assert property (HW_TRAP_EVENT != 8'h00 |=>
    (TRAP_FLAGS & $past(HW_TRAP_EVENT)) == $past(HW_TRAP_EVENT)) else $error("flag lost");
  a_class_a: assert property (go && $onehot(ha) |=> ENTRY.valid &&
    ENTRY.is_hw_trap && ENTRY.trap_number == $past(na)) else $error("bad class A");
  a_class_b: assert property (go && ha == 4'h0 && HW_TRAP_EVENT != 8'h00 |=>
    ENTRY.valid && ENTRY.trap_number == TRAP_CLASS_B) else $error("bad class B");
  a_soft_trap: assert property (calm && SW_TRAP_REQ |=> ENTRY.valid &&
    ENTRY.trap_number == $past(SW_TRAP_NUMBER)) else $error("bad soft trap");
  a_node_number: assert property (calm && !SW_TRAP_REQ && IRQ_REQ[0] |=>
    ENTRY.valid && ENTRY.trap_number == TRAP_MOTOR_TIMER_A) else $error("bad node");
  a_trap_block: assert property (IN_TRAP_SERVICE && RESET_EVENT == 3'h0 &&
    HW_TRAP_EVENT == 8'h00 |=> !ENTRY.valid && !PEC_GRANT) else $error("preempted");
endmodule
bind tvu_trap_unit tvu_chk #(.NODES(NODES)) chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .SW_TRAP_REQ(SW_TRAP_REQ), .IN_TRAP_SERVICE(IN_TRAP_SERVICE), .PEC_GRANT(PEC_GRANT),
  .CFG(CFG), .RESET_EVENT(RESET_EVENT), .HW_TRAP_EVENT(HW_TRAP_EVENT),
  .TRAP_FLAGS(TRAP_FLAGS), .SW_TRAP_NUMBER(SW_TRAP_NUMBER), .IRQ_REQ(IRQ_REQ),
  .ENTRY(ENTRY));

// *** verif/tvu_core_model.sv ***
`timescale 1ns/1ps
module tvu_core_model import tvu_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire tvu_entry_t ENTRY,
  output logic DONE);
  // Routine returns a few cycles after entry, leaving room to try preemption
  logic [2:0] cnt_r;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= ENTRY.valid && ENTRY.is_hw_trap ? 3'h4 : cnt_r - 3'(cnt_r != 3'h0);
    end
  end
  assign DONE = cnt_r == 3'h1;
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top import tvu_pkg::*; ;
  logic CLOCK = 0, RST_N = 0, SW_TRAP_REQ = 0, PEC_REQ = 0, TRAP_SERVICE_DONE, IN_TRAP_SERVICE, PEC_GRANT;
  logic [2:0] RESET_EVENT = 0;
  logic [7:0] HW_TRAP_EVENT = 0, FLAG_CLEAR = 0, TRAP_FLAGS;
  logic [6:0] SW_TRAP_NUMBER = 0;
  logic [1:0] IRQ_REQ = 0;
  tvu_cfg_t CFG = {8'h12, 2'h0};
  tvu_entry_t ENTRY;
  int miscompares = 0, samples_checked = 0;
  always #12.5 CLOCK = ~CLOCK;
  tvu_trap_unit dut (.CLOCK(CLOCK), .RST_N(RST_N), .CFG(CFG), .RESET_EVENT(RESET_EVENT),
    .HW_TRAP_EVENT(HW_TRAP_EVENT), .SW_TRAP_REQ(SW_TRAP_REQ), .SW_TRAP_NUMBER(SW_TRAP_NUMBER),
    .IRQ_REQ(IRQ_REQ), .PEC_REQ(PEC_REQ), .TRAP_SERVICE_DONE(TRAP_SERVICE_DONE),
    .FLAG_CLEAR(FLAG_CLEAR), .ENTRY(ENTRY), .TRAP_FLAGS(TRAP_FLAGS),
    .IN_TRAP_SERVICE(IN_TRAP_SERVICE), .PEC_GRANT(PEC_GRANT));
  tvu_core_model core (.CLOCK(CLOCK), .RST_N(RST_N), .ENTRY(ENTRY), .DONE(TRAP_SERVICE_DONE));
  task cmp(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task ent_is(string s, logic [6:0] n, logic [15:0] o);
    cmp(s, {1'b1, n, CFG.vector_segment, o}, {ENTRY.valid, ENTRY.trap_number, ENTRY.vector_address});
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task fire(logic [2:0] r, logic [7:0] h, logic s, logic [1:0] q);
    // A quiet cycle first, so a pulse is never cleared and raised in one step
    @(negedge CLOCK);
    {RESET_EVENT, HW_TRAP_EVENT, SW_TRAP_REQ, IRQ_REQ} = {r, h, s, q};
    @(negedge CLOCK);
    {RESET_EVENT, HW_TRAP_EVENT, SW_TRAP_REQ, IRQ_REQ} = 0;
  endtask
  task idle;
    for (int i = 0; i < 20 && IN_TRAP_SERVICE !== 1'b0; i++) @(negedge CLOCK);
    if (IN_TRAP_SERVICE !== 1'b0) begin
      miscompares++;
      test_done;
    end
  endtask
  initial begin
    repeat (6) @(negedge CLOCK);
    RST_N = 1;
    for (int i = 0; i < 3; i++) begin
      fire(3'h1 << i, 0, 0, 0);
      ent_is("reset", 0, 0);
    end
    cmp("flags", 0, 32'(TRAP_FLAGS));
    for (int k = 0; k < 8; k++) begin
      fire(0, 8'h01 << k, 0, 0);
      if (k < 4) ent_is("class_a", 7'(2 * k + 2), 16'(8 * k + 8));
      else ent_is("class_b", 7'h0A, 16'h0028);
      idle;
    end
    cmp("flags", 8'hFF, 32'(TRAP_FLAGS));
    PEC_REQ = 1;
    @(negedge CLOCK);
    {FLAG_CLEAR, HW_TRAP_EVENT} = {8'hFF, 8'h01};
    @(negedge CLOCK);
    {FLAG_CLEAR, HW_TRAP_EVENT} = 0;
    ent_is("nmi", 7'h02, 16'h0008);
    cmp("set_wins", 8'h01, 32'(TRAP_FLAGS));
    fire(0, 0, 1, 2'h1);
    cmp("refused", 1, {ENTRY.valid, PEC_GRANT, TRAP_FLAGS});
    idle;
    @(negedge CLOCK);
    cmp("grant", 1, 32'(PEC_GRANT));
    PEC_REQ = 0;
    for (int j = 0; j < 4; j++) begin
      CFG.vector_spacing = 2'(j / 2);
      SW_TRAP_NUMBER = j[0] ? 7'h7F : 7'h00;
      fire(0, 0, 1, 0);
      ent_is("soft", SW_TRAP_NUMBER, j[0] ? 16'h01FC << j[1] : 16'h0000);
    end
    CFG.vector_spacing = 0;
    fire(0, 0, 0, 2'h1);
    ent_is("node", 7'h4D, 16'h0134);
    fire(0, 0, 0, 2'h2);
    ent_is("node", 7'h5D, 16'h0174);
    test_done;
  end
endmodule
